// ===== verilog/flash_boot_program_verify_seq.sv
// boot entry, mode handling and program/verify control of the on-chip flash
//
// How it works
// - after boot reset release, wait about 100 clocks before timing the receive line.
// - entering boot, any flash word not all ones triggers an erase of all blocks.
// - before the user jump, serial enables clear, divisor kept, port 8 bit 4 high.
// - boot detected at release frees the three port 9 select pins for general use.
// - a watchdog overflow reset also leaves boot mode.
// - in reset, mode 1 drives address ports low; strobes high unless mode 3.
// - programming only in a flash-enabled start mode; other units run normally.
// - while write enable is set, normal flash reads return nothing useful.
// - address and data of the 32 consecutive byte writes are latched.
// - a verify read returns the 16-bit word at the dummy-written address.
// - boot times a zero byte's low period for the rate and replies with zero.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_consts.svh"
module flash_boot_program_verify_seq
  import flash_seq_pkg::*;
#(
  parameter int FLASH_BYTES = `FLASH_BYTES,
  parameter int MEAS_W = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wdt_reset,
  // mode straps
  input wire flash_seq_pkg::mode_pins_t mode_pins,
  input wire logic [2:0] boot_sel_pins,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // cpu access to the flash space
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic fl_wr,
  input wire logic fl_rd,
  output logic [15:0] fl_rdata,
  // flash array
  output logic [15:0] arr_addr,
  input wire logic [15:0] arr_rdata,
  output logic arr_prog,
  output logic [15:0] arr_prog_base,
  output logic [8*`PAGE_BYTES-1:0] arr_prog_data,
  output logic arr_erase_all,
  // boot serial link and neighbours
  input wire logic rxd,
  output logic txd,
  output logic tx_enable_bit,
  output logic rx_enable_bit,
  output logic [15:0] baud_divisor,
  output logic port8_bit4_direction,
  output logic port8_bit4_output,
  output logic p9_gpio_en,
  output logic jump_req,
  output logic [15:0] jump_addr,
  // pin states while in reset
  output logic addr_port_oe,
  output logic strobe_oe,
  output logic strobe_level
);
  import flash_seq_pkg::*;

  page_if #(.AW(16), .N(`PAGE_BYTES)) pg ();

  boot_state_t state_reg;
  mode_pins_t mode_reg;
  logic captured_reg, boot_reg;
  logic [7:0] ctrl_one_reg, ctrl_two_reg, serial_ctrl_reg, rdata_reg;
  logic [15:0] baud_divisor_reg, fl_rdata_reg, verify_addr_reg, arr_addr_reg, jump_addr_reg;
  logic [1:0] port8_reg;
  logic [MEAS_W-1:0] meas_reg;
  logic [15:0] quot_reg, bit_cnt_reg;
  logic [3:0] pre_reg, reply_bits_reg;
  logic [$clog2(FLASH_BYTES):0] scan_reg;
  logic rd_pend_reg, rd_block_reg, scan_check_reg, dirty_reg;
  logic arr_prog_reg, arr_erase_reg, txd_reg, jump_reg;
  logic addr_oe_reg, strobe_oe_reg, strobe_level_reg;
  logic wen, setup, prog, verify, flash_en, bit_tick, scan_done;

  localparam int READY_CYC = `BOOT_READY_STATES;
  localparam int UNIT = `LOW_BITS * `PRESCALE;
  localparam int WORDS = FLASH_BYTES / 2;

  assign wen = ctrl_one_reg[`WEN_POS];
  assign setup = ctrl_two_reg[`SETUP_POS];
  assign prog = ctrl_one_reg[`PROG_POS];
  assign verify = ctrl_one_reg[`VERIFY_POS];
  // flash-enabled start modes are 2 and 3; boot counts as enabled
  assign flash_en = boot_reg || mode_reg[1];
  assign scan_done = (scan_reg == ($clog2(FLASH_BYTES)+1)'(WORDS));

  // no reset here on purpose: these follow the mode pins while the chip is held in reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      addr_oe_reg <= (mode_pins == `MODE1_PINS);
      strobe_oe_reg <= (mode_pins != `MODE3_PINS);
    end
    strobe_level_reg <= 1'b1;
  end

  // straps are caught on the first edge after release, and again after a watchdog reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      captured_reg <= 1'b0;
      mode_reg <= 2'h0;
      boot_reg <= 1'b0;
    end else if (wdt_reset) begin
      mode_reg <= mode_pins;
      boot_reg <= 1'b0;
    end else if (!captured_reg) begin
      captured_reg <= 1'b1;
      mode_reg <= mode_pins;
      boot_reg <= (mode_pins == `BOOT_MODE_PINS) && (boot_sel_pins == `BOOT_SEL_PINS);
    end
  end

  // boot sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= BS_USER;
    end else if (wdt_reset) begin
      state_reg <= BS_USER;
    end else begin
      unique case (state_reg)
        BS_USER: if (!captured_reg && mode_pins == `BOOT_MODE_PINS && boot_sel_pins == `BOOT_SEL_PINS) begin
          state_reg <= BS_READY_WAIT;
        end
        BS_READY_WAIT: if (meas_reg == MEAS_W'(READY_CYC - 1)) begin
          state_reg <= BS_WAIT_LOW;
        end
        BS_WAIT_LOW: if (!rxd) begin
          state_reg <= BS_MEASURE;
        end
        BS_MEASURE: if (rxd) begin
          state_reg <= BS_DIVIDE;
        end
        BS_DIVIDE: if (meas_reg < MEAS_W'(UNIT)) begin
          state_reg <= BS_REPLY;
        end
        BS_REPLY: if (bit_tick && reply_bits_reg == 4'(`REPLY_BITS - 1)) begin
          state_reg <= BS_BLANK;
        end
        BS_BLANK: if (scan_done && !scan_check_reg) begin
          state_reg <= dirty_reg ? BS_ERASE : BS_HANDOFF;
        end
        BS_ERASE: state_reg <= BS_HANDOFF;
        BS_HANDOFF: state_reg <= BS_RUN;
        BS_RUN: state_reg <= BS_RUN;
        default: state_reg <= BS_USER;
      endcase
    end
  end

  // shared counter: ready delay, then low-period width, then remainder of the division
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meas_reg <= '0;
      quot_reg <= '0;
    end else if (state_reg == BS_READY_WAIT) begin
      meas_reg <= (meas_reg == MEAS_W'(READY_CYC - 1)) ? '0 : meas_reg + MEAS_W'(1);
      quot_reg <= '0;
    end else if (state_reg == BS_MEASURE && !rxd && meas_reg != '1) begin
      meas_reg <= meas_reg + MEAS_W'(1);
    end else if (state_reg == BS_DIVIDE && meas_reg >= MEAS_W'(UNIT)) begin
      meas_reg <= meas_reg - MEAS_W'(UNIT);
      quot_reg <= quot_reg + 16'h0001;
    end
  end

  // bit timer: prescale by 16, then the measured divisor
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= '0;
      bit_cnt_reg <= '0;
    end else if (state_reg != BS_REPLY) begin
      pre_reg <= '0;
      bit_cnt_reg <= '0;
    end else if (pre_reg == 4'(`PRESCALE - 1)) begin
      pre_reg <= '0;
      bit_cnt_reg <= bit_tick ? 16'h0000 : bit_cnt_reg + 16'h0001;
    end else begin
      pre_reg <= pre_reg + 4'h1;
    end
  end
  assign bit_tick = (pre_reg == 4'(`PRESCALE - 1)) &&
                    (bit_cnt_reg + 16'h0001 >= baud_divisor_reg);

  // reply byte: start bit and eight zero bits, then stop bit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reply_bits_reg <= '0;
      txd_reg <= 1'b1;
    end else if (state_reg == BS_REPLY) begin
      txd_reg <= (reply_bits_reg == 4'(`REPLY_BITS - 1));
      if (bit_tick) begin
        reply_bits_reg <= reply_bits_reg + 4'h1;
      end
    end else begin
      reply_bits_reg <= '0;
      txd_reg <= 1'b1;
    end
  end

  // blank check sweeps every word; data of an address is checked one cycle later
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scan_reg <= '0;
      scan_check_reg <= 1'b0;
      dirty_reg <= 1'b0;
    end else if (state_reg == BS_BLANK) begin
      scan_check_reg <= !scan_done;
      if (!scan_done) begin
        scan_reg <= scan_reg + ($clog2(FLASH_BYTES)+1)'(1);
      end
      if (scan_check_reg && arr_rdata != `ERASED_WORD) begin
        dirty_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arr_erase_reg <= 1'b0;
      jump_reg <= 1'b0;
      jump_addr_reg <= 16'h0000;
    end else begin
      arr_erase_reg <= (state_reg == BS_ERASE);
      jump_reg <= (state_reg == BS_HANDOFF);
      if (state_reg == BS_HANDOFF) begin
        jump_addr_reg <= `USER_ENTRY;
      end
    end
  end

  // flash control registers; a watchdog reset drops the mode bits, a cleared write enable drops program and verify but not setup
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_one_reg <= `CTRL_ONE_RST;
      ctrl_two_reg <= `CTRL_TWO_RST;
    end else if (wdt_reset) begin
      ctrl_one_reg <= `CTRL_ONE_RST;
      ctrl_two_reg <= `CTRL_TWO_RST;
    end else if (reg_wr && reg_addr == `OFS_CTRL_ONE) begin
      ctrl_one_reg <= 8'h00;
      ctrl_one_reg[`WEN_POS] <= reg_wdata[`WEN_POS] && flash_en;
      ctrl_one_reg[`PROG_POS] <= reg_wdata[`PROG_POS] && reg_wdata[`WEN_POS] && flash_en;
      ctrl_one_reg[`VERIFY_POS] <= reg_wdata[`VERIFY_POS] && reg_wdata[`WEN_POS] && flash_en;
    end else if (reg_wr && reg_addr == `OFS_CTRL_TWO) begin
      ctrl_two_reg <= {7'h00, reg_wdata[`SETUP_POS] && wen};
    end
  end

  // serial enables: set by boot for the alignment, cleared before the jump, else software owned
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      serial_ctrl_reg <= `SERIAL_CTRL_RST;
      baud_divisor_reg <= `BAUD_RST;
      port8_reg <= `PORT8_RST;
    end else if (state_reg == BS_WAIT_LOW) begin
      serial_ctrl_reg[`TXEN_POS] <= 1'b1;
      serial_ctrl_reg[`RXEN_POS] <= 1'b1;
    end else if (state_reg == BS_DIVIDE && meas_reg < MEAS_W'(UNIT)) begin
      baud_divisor_reg <= (quot_reg == 16'h0000) ? 16'h0001 : quot_reg;
    end else if (state_reg == BS_HANDOFF) begin
      serial_ctrl_reg[`TXEN_POS] <= 1'b0;
      serial_ctrl_reg[`RXEN_POS] <= 1'b0;
      port8_reg <= 2'h3;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `OFS_SERIAL_CTRL: serial_ctrl_reg <= reg_wdata;
        `OFS_BAUD_LO: baud_divisor_reg[7:0] <= reg_wdata;
        `OFS_BAUD_HI: baud_divisor_reg[15:8] <= reg_wdata;
        `OFS_PORT8: port8_reg <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // register reads answer in the next cycle; unmapped offsets read zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFS_CTRL_ONE: rdata_reg <= ctrl_one_reg;
        `OFS_CTRL_TWO: rdata_reg <= ctrl_two_reg;
        `OFS_SERIAL_CTRL: rdata_reg <= serial_ctrl_reg;
        `OFS_BAUD_LO: rdata_reg <= baud_divisor_reg[7:0];
        `OFS_BAUD_HI: rdata_reg <= baud_divisor_reg[15:8];
        `OFS_PORT8: rdata_reg <= {6'h00, port8_reg};
        `OFS_STATUS: rdata_reg <= {2'h0, pg.full, arr_prog_reg, mode_reg, flash_en, boot_reg};
        `OFS_BOOT_STATE: rdata_reg <= {4'h0, state_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  // byte writes to flash space feed the program latch; in verify they set the read address and empty the latch
  assign pg.wr = fl_wr && wen && !verify && !prog && flash_en;
  assign pg.addr = fl_addr;
  assign pg.data = fl_wdata;
  assign pg.clr = !wen || (fl_wr && verify);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      verify_addr_reg <= 16'h0000;
    end else if (fl_wr && wen && verify) begin
      verify_addr_reg <= {fl_addr[15:1], 1'b0};
    end
  end

  // array address: blank sweep during boot, otherwise the cpu or the latched verify address
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arr_addr_reg <= 16'h0000;
    end else if (state_reg == BS_BLANK) begin
      // the cast fits any scan width to the 16-bit word address
      arr_addr_reg <= 16'({scan_reg, 1'b0});
    end else if (fl_rd) begin
      arr_addr_reg <= (wen && verify) ? verify_addr_reg : {fl_addr[15:1], 1'b0};
    end
  end

  // two-cycle read: address out, then the array word is captured
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_pend_reg <= 1'b0;
      rd_block_reg <= 1'b0;
      fl_rdata_reg <= 16'h0000;
    end else begin
      rd_pend_reg <= fl_rd;
      if (fl_rd) begin
        rd_block_reg <= wen && !verify;
      end
      if (rd_pend_reg) begin
        fl_rdata_reg <= rd_block_reg ? 16'h0000 : arr_rdata;
      end
    end
  end

  // the array programs only while enable, setup and program are all held with a full unit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arr_prog_reg <= 1'b0;
    end else begin
      arr_prog_reg <= wen && setup && prog && !verify && flash_en && pg.full && !wdt_reset;
    end
  end

  page_latch #(.AW(16), .N(`PAGE_BYTES)) u_page (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pg(pg)
  );

  assign reg_rdata = rdata_reg;
  assign fl_rdata = fl_rdata_reg;
  assign arr_addr = arr_addr_reg;
  assign arr_prog = arr_prog_reg;
  assign arr_prog_base = pg.base;
  assign arr_prog_data = pg.bytes;
  assign arr_erase_all = arr_erase_reg;
  assign txd = txd_reg;
  assign tx_enable_bit = serial_ctrl_reg[`TXEN_POS];
  assign rx_enable_bit = serial_ctrl_reg[`RXEN_POS];
  assign baud_divisor = baud_divisor_reg;
  assign port8_bit4_direction = port8_reg[`P8_DIR_POS];
  assign port8_bit4_output = port8_reg[`P8_OUT_POS];
  assign p9_gpio_en = boot_reg;
  assign jump_req = jump_reg;
  assign jump_addr = jump_addr_reg;
  assign addr_port_oe = addr_oe_reg;
  assign strobe_oe = strobe_oe_reg;
  assign strobe_level = strobe_level_reg;
endmodule : flash_boot_program_verify_seq
`default_nettype wire

// ===== verilog/flash_seq_consts.svh
// offsets, field positions, reset values and counts of the flash sequencer
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h01
`define OFS_SERIAL_CTRL 8'h02
`define OFS_BAUD_LO 8'h03
`define OFS_BAUD_HI 8'h04
`define OFS_PORT8 8'h05
`define OFS_STATUS 8'h06
`define OFS_BOOT_STATE 8'h07
`define WEN_POS 7
`define VERIFY_POS 2
`define PROG_POS 0
`define SETUP_POS 0
`define TXEN_POS 5
`define RXEN_POS 4
`define P8_DIR_POS 1
`define P8_OUT_POS 0
`define CTRL_ONE_RST 8'h00
`define CTRL_TWO_RST 8'h00
`define SERIAL_CTRL_RST 8'h00
`define BAUD_RST 16'h0000
`define PORT8_RST 2'h0
`define BOOT_READY_STATES 100
`define LOW_BITS 9
`define PRESCALE 16
`define REPLY_BITS 10
`define USER_ENTRY 16'he880
`define ERASED_WORD 16'hffff
`define ERASED_BYTE 8'hff
`define BOOT_MODE_PINS 2'h0
`define BOOT_SEL_PINS 3'h7
`define MODE1_PINS 2'h1
`define MODE3_PINS 2'h3
`define PAGE_BYTES 32
`define FLASH_BYTES 61440
`endif

// ===== verilog/flash_seq_pkg.sv
// types shared by the flash sequencer modules
package flash_seq_pkg;
  typedef enum logic [3:0] {
    BS_USER = 4'h0,
    BS_READY_WAIT = 4'h1,
    BS_WAIT_LOW = 4'h2,
    BS_MEASURE = 4'h3,
    BS_DIVIDE = 4'h4,
    BS_REPLY = 4'h5,
    BS_BLANK = 4'h6,
    BS_ERASE = 4'h7,
    BS_HANDOFF = 4'h8,
    BS_RUN = 4'h9
  } boot_state_t;
  typedef logic [1:0] mode_pins_t;
endpackage : flash_seq_pkg

// ===== verilog/page_if.sv
// carrier between the sequencer and its 32-byte program latch
`timescale 1ns/10ps
`default_nettype none
interface page_if #(parameter int AW = 16, parameter int N = 32);
  logic wr;
  logic clr;
  logic [AW-1:0] addr;
  logic [7:0] data;
  logic full;
  logic [AW-1:0] base;
  logic [8*N-1:0] bytes;
  modport writer (output wr, output clr, output addr, output data, input full, input base, input bytes);
  modport store (input wr, input clr, input addr, input data, output full, output base, output bytes);
endinterface : page_if
`default_nettype wire

// ===== verilog/page_latch.sv
// latches address and data of the consecutive byte writes of one program unit
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_consts.svh"
module page_latch #(
  parameter int AW = 16,
  parameter int N = `PAGE_BYTES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // link to the sequencer
  page_if.store pg
);
  localparam int IW = $clog2(N);
  logic [IW:0] count_reg;
  logic [AW-1:0] base_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else if (pg.clr) begin
      count_reg <= '0;
    end else if (pg.wr && count_reg != (IW+1)'(N)) begin
      count_reg <= count_reg + (IW+1)'(1);
    end
  end

  // the unit base comes from its first write; low bits are forced to the unit boundary
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      base_reg <= '0;
    end else if (pg.wr && count_reg == '0) begin
      base_reg <= {pg.addr[AW-1:IW], {IW{1'b0}}};
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_entry
      logic [7:0] byte_reg;
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          byte_reg <= `ERASED_BYTE;
        end else if (pg.clr) begin
          byte_reg <= `ERASED_BYTE;
        end else if (pg.wr && pg.addr[IW-1:0] == IW'(i)) begin
          byte_reg <= pg.data;
        end
      end
      assign pg.bytes[8*i +: 8] = byte_reg;
    end
  endgenerate

  assign pg.full = (count_reg == (IW+1)'(N));
  assign pg.base = base_reg;
endmodule : page_latch
`default_nettype wire

// ===== verif/flash_array_model.sv
// behavioural flash array on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  // clock
  input wire logic sys_clk,
  // array port
  input wire logic [15:0] arr_addr,
  output logic [15:0] arr_rdata,
  input wire logic arr_prog,
  input wire logic [15:0] arr_prog_base,
  input wire logic [255:0] arr_prog_data,
  input wire logic arr_erase_all
);
  logic [7:0] mem [0:511];
  // only a window of the space is modelled; upper address bits alias
  assign arr_rdata = {mem[{arr_addr[8:1], 1'b0}], mem[{arr_addr[8:1], 1'b1}]};
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'hff;
    end
    // stale contents so that boot entry has something to erase
    mem[3] = 8'h5a;
  end
  always @(posedge sys_clk) begin
    if (arr_erase_all) begin
      for (int i = 0; i < 512; i++) begin
        mem[i] = 8'hff;
      end
    end else if (arr_prog) begin
      // a cell can only be pulled to 0, so reprogramming cannot restore ones
      for (int i = 0; i < 32; i++) begin
        mem[(arr_prog_base[8:0] + i) % 512] &= arr_prog_data[8*i +: 8];
      end
    end
  end
endmodule : flash_array_model
`default_nettype wire

// ===== verif/flash_boot_program_verify_seq_properties.sv
// port-level assertions of the flash sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_boot_program_verify_seq_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wdt_reset,
  // straps
  input wire logic [1:0] mode_pins,
  input wire logic [2:0] boot_sel_pins,
  // flash side
  input wire logic fl_rd,
  input wire logic [15:0] fl_rdata,
  input wire logic [15:0] arr_addr,
  input wire logic [15:0] arr_rdata,
  input wire logic arr_prog,
  input wire logic [15:0] arr_prog_base,
  input wire logic [255:0] arr_prog_data,
  input wire logic arr_erase_all,
  // boot link and neighbours
  input wire logic txd,
  input wire logic tx_enable_bit,
  input wire logic rx_enable_bit,
  input wire logic [15:0] baud_divisor,
  input wire logic port8_bit4_direction,
  input wire logic port8_bit4_output,
  input wire logic p9_gpio_en,
  input wire logic jump_req,
  input wire logic [15:0] jump_addr,
  input wire logic addr_port_oe,
  input wire logic strobe_oe,
  input wire logic strobe_level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [23:0] low_cnt;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 24'h000000;
    end else if (txd) begin
      low_cnt <= 24'h000000;
    end else begin
      low_cnt <= low_cnt + 24'h000001;
    end
  end
  sequence exit_state_s;
    (jump_addr == 16'he880) && !tx_enable_bit && !rx_enable_bit && port8_bit4_direction && port8_bit4_output;
  endsequence
  sequence boot_release_s;
    $rose(nrst) && (mode_pins == 2'h0) && (boot_sel_pins == 3'h7);
  endsequence
  // the pin states exist only while reset is low, so reset cannot disable this one
  reset_pins_a: assert property (disable iff (1'b0) (!nrst ##1 !nrst) |->
    addr_port_oe == ($past(mode_pins) == 2'h1) && strobe_oe == ($past(mode_pins) != 2'h3) && strobe_level)
    else $error("reset pin states wrong for mode");
  pins_hold_a: assert property (nrst && $past(nrst) |-> $stable({addr_port_oe, strobe_oe, strobe_level}))
    else $error("reset pin states moved while running");
  handoff_state_a: assert property (jump_req |=> exit_state_s and (baud_divisor == $past(baud_divisor)))
    else $error("hand-off left wrong serial or port state");
  jump_pulse_a: assert property (jump_req |=> !jump_req)
    else $error("jump request longer than one cycle");
  erase_pulse_a: assert property (arr_erase_all |=> !arr_erase_all)
    else $error("erase pulse longer than one cycle");
  reply_low_a: assert property ($rose(txd) |-> low_cnt == 24'(144 * baud_divisor))
    else $error("reply low period not nine bit times");
  boot_ports_a: assert property (boot_release_s |-> ##[1:2] p9_gpio_en)
    else $error("select pins not freed in boot");
  wdt_exit_a: assert property (wdt_reset |-> ##2 !arr_prog)
    else $error("program still active after watchdog reset");
  verify_word_a: assert property (fl_rd |-> ##2 (fl_rdata == $past(arr_rdata)) || (fl_rdata == 16'h0000))
    else $error("flash read result not taken from the array");
  unit_latch_a: assert property (arr_prog && $past(arr_prog) |->
    arr_prog_base[4:0] == 5'h00 && $stable(arr_prog_base) && $stable(arr_prog_data))
    else $error("program unit moved while programming");
endmodule : flash_boot_program_verify_seq_properties
`default_nettype wire

// ===== verif/flash_boot_program_verify_seq_bench.sv
// self-checking bench of the flash sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_boot_program_verify_seq_bench;
  import flash_seq_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, wdt_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fl_wr = 1'b0, fl_rd = 1'b0;
  logic rxd = 1'b1;
  mode_pins_t mode_pins = 2'h0;
  logic [2:0] boot_sel_pins = 3'h7;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fl_wdata = 8'h00, reg_rdata;
  logic [15:0] fl_addr = 16'h0000, fl_rdata, arr_addr, arr_rdata, arr_prog_base, baud_divisor, jump_addr;
  logic arr_prog, arr_erase_all, txd, tx_enable_bit, rx_enable_bit, port8_bit4_direction, port8_bit4_output;
  logic p9_gpio_en, jump_req, addr_port_oe, strobe_oe, strobe_level;
  logic [255:0] arr_prog_data, exp_data;
  int err_total = 0, num_checks = 0, cyc = 0, erase_cnt = 0;
  always #2 sys_clk = ~sys_clk;
  flash_boot_program_verify_seq #(.FLASH_BYTES(64)) DUT (.sys_clk, .nrst, .wdt_reset, .mode_pins, .boot_sel_pins,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fl_addr, .fl_wdata, .fl_wr, .fl_rd, .fl_rdata,
    .arr_addr, .arr_rdata, .arr_prog, .arr_prog_base, .arr_prog_data, .arr_erase_all, .rxd, .txd,
    .tx_enable_bit, .rx_enable_bit, .baud_divisor, .port8_bit4_direction, .port8_bit4_output, .p9_gpio_en,
    .jump_req, .jump_addr, .addr_port_oe, .strobe_oe, .strobe_level);
  flash_array_model array_model (.sys_clk, .arr_addr, .arr_rdata, .arr_prog, .arr_prog_base, .arr_prog_data,
    .arr_erase_all);
  task automatic final_report();
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [255:0] s, input logic [255:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // straps are set together with reset, well ahead of the release edge
  task automatic rst(input mode_pins_t m, input int n);
    @(posedge sys_clk) nrst <= 1'b0;
    mode_pins <= m;
    repeat (n) @(posedge sys_clk);
    #1 chk("addr_port_oe", addr_port_oe, m == 2'h1);
    chk("strobes", {strobe_oe, strobe_level}, {m != 2'h3, 1'b1});
    @(posedge sys_clk) nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk) reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask : rd
  task automatic flw(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) fl_addr <= a;
    fl_wdata <= d;
    fl_wr <= 1'b1;
    @(posedge sys_clk) fl_wr <= 1'b0;
  endtask : flw
  task automatic flr(input logic [15:0] a, input logic [15:0] e);
    @(posedge sys_clk) fl_addr <= a;
    fl_rd <= 1'b1;
    @(posedge sys_clk) fl_rd <= 1'b0;
    @(posedge sys_clk);
    #1 chk("fl_rdata", fl_rdata, e);
  endtask : flr
  always @(posedge sys_clk) begin
    cyc++;
    if (arr_erase_all === 1'b1) begin
      erase_cnt++;
    end
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    rst(2'h0, 10);
    // the host holds the line high well past the ready time, then sends a zero byte
    repeat (110) @(posedge sys_clk);
    rxd <= 1'b0;
    repeat (300) @(posedge sys_clk);
    rxd <= 1'b1;
    @(posedge sys_clk);
    #1 while (jump_req !== 1'b1) @(posedge sys_clk) #1;
    @(posedge sys_clk);
    #1 chk("baud_divisor", baud_divisor, 16'h0002);
    chk("jump_addr", jump_addr, 16'he880);
    chk("port8", {port8_bit4_direction, port8_bit4_output, tx_enable_bit, rx_enable_bit}, 4'hc);
    chk("p9_gpio_en", p9_gpio_en, 1'b1);
    chk("erase_cnt", erase_cnt, 1);
    rd(8'h02, 8'h00);
    @(posedge sys_clk) wdt_reset <= 1'b1;
    @(posedge sys_clk) wdt_reset <= 1'b0;
    rd(8'h07, 8'h00);
    // leaving boot by the pin needs at least 20 clocks of reset
    rst(2'h3, 20);
    rst(2'h1, 20);
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h00);
    rst(2'h2, 20);
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h80);
    flr(16'h0000, 16'h0000);
    for (int i = 0; i < 32; i++) begin
      flw(16'h0120 + 16'(i), 8'h10 + 8'(i));
      exp_data[8*i +: 8] = 8'h10 + 8'(i);
    end
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h81);
    @(posedge sys_clk);
    #1 chk("arr_prog", arr_prog, 1'b1);
    chk("arr_prog_base", arr_prog_base, 16'h0120);
    chk("arr_prog_data", arr_prog_data, exp_data);
    wr(8'h00, 8'h80);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h84);
    flw(16'h0124, 8'hff);
    flr(16'h0124, 16'h1415);
    wr(8'h00, 8'h80);
    // the dummy write emptied the latch; refill it with all ones so the watchdog cuts a live pulse
    for (int i = 0; i < 32; i++) begin
      flw(16'h0120 + 16'(i), 8'hff);
    end
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h81);
    @(posedge sys_clk);
    #1 chk("arr_prog", arr_prog, 1'b1);
    @(posedge sys_clk) wdt_reset <= 1'b1;
    @(posedge sys_clk) wdt_reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk("arr_prog", arr_prog, 1'b0);
    rd(8'h00, 8'h00);
    final_report();
  end
endmodule : flash_boot_program_verify_seq_bench
bind flash_boot_program_verify_seq flash_boot_program_verify_seq_properties props (.sys_clk, .nrst, .wdt_reset,
  .mode_pins, .boot_sel_pins, .fl_rd, .fl_rdata, .arr_addr, .arr_rdata, .arr_prog, .arr_prog_base, .arr_prog_data,
  .arr_erase_all, .txd, .tx_enable_bit, .rx_enable_bit, .baud_divisor, .port8_bit4_direction, .port8_bit4_output,
  .p9_gpio_en, .jump_req, .jump_addr, .addr_port_oe, .strobe_oe, .strobe_level);
`default_nettype wire
